/* rtl/flash_cmd_map.svh */
// opcode values, phase lengths and status layout of the flash command decoder
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define OP_WL_SET   8'h06
`define OP_WL_CLR   8'h04
`define OP_ID       8'h9f
`define OP_STATUS   8'h05
`define OP_STWR     8'h01
`define OP_RD_DDR1  8'h0d
`define OP_RD_DDR2  8'hbd
`define OP_RD_DDR4  8'hed
`define OP_RD       8'h03
`define OP_RD_FAST  8'h0b
`define OP_RD_2IO   8'hbb
`define OP_RD_2OUT  8'h3b
`define OP_RD_4IO   8'heb
`define OP_RD_4OUT  8'h6b
`define OP_PG       8'h02
`define OP_PG4      8'h38
`define OP_ER_S     8'h20
`define OP_ER_B     8'hd8
`define OP_ER_H     8'h52
`define OP_ER_C1    8'h60
`define OP_ER_C2    8'hc7
`define OP_CP       8'had
`define OP_SLEEP    8'hb9
`define OP_WAKE     8'hab
`define LANE_1      3'd1
`define LANE_2      3'd2
`define LANE_4      3'd4
`define ACLK_24     5'd24
`define ACLK_12     5'd12
`define ACLK_6      5'd6
`define ACLK_3      5'd3
`define DUM_DDR12   5'd6
`define DUM_DDR4    5'd8
`define DUM_FAST    5'd8
`define DUM_2IO     5'd4
`define DUM_4IO     5'd6
`define DUM_ES      5'd24
`define OPC_CLKS    5'd8
`define BYTE_BITS   4'd8
`define CLKS_BARE   12'd8
`define CLKS_ADDR   12'd32
`define CLKS_STWR   12'd16
`define CLKS_MAX    12'hfff
`define STAT_WEL    3'd1
`define STAT_WR_MSK 8'hfc
`define STAT_RST    8'h00
`endif

/* rtl/flash_cmd_pkg.sv */
// types shared by the flash command decoder
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_WL_SET = 4'h1, K_WL_CLR = 4'h2, K_ID = 4'h3,
    K_STATUS = 4'h4, K_STWR = 4'h5, K_READ = 4'h6, K_PROG = 4'h7,
    K_ER_S = 4'h8, K_ER_H = 4'h9, K_ER_B = 4'ha, K_ER_C = 4'hb,
    K_CPROG = 4'hc, K_SLEEP = 4'hd, K_WAKE = 4'he
  } kind_t;
  typedef enum logic [2:0] {
    PH_OPC = 3'b000, PH_ADDR = 3'b001, PH_DUM = 3'b010,
    PH_DIN = 3'b011, PH_DOUT = 3'b100, PH_IDLE = 3'b101
  } phase_t;
  typedef enum logic [1:0] {
    ER_SECTOR = 2'b00, ER_HALF = 2'b01, ER_BLOCK = 2'b10, ER_CHIP = 2'b11
  } erase_t;
  typedef struct packed {
    kind_t      kind;
    logic       ddr;
    logic [2:0] aw;
    logic [4:0] aclk;
    logic [4:0] dum;
    logic [2:0] dw;
    logic       dout;
  } cmd_t;
  typedef struct packed {
    phase_t      phase;
    cmd_t        cmd;
    logic [7:0]  opc;
    logic [11:0] clks;
    logic [4:0]  cnt;
    logic [23:0] addr;
    logic [7:0]  sh;
    logic [3:0]  left;
    logic [3:0]  pend;
    logic [3:0]  out_fall;
    logic [3:0]  out_rise;
    logic [3:0]  oe;
    logic [1:0]  idx;
    logic        cp_on;
    logic        ftgl;
    logic        pg_tgl;
    logic [23:0] pg_addr;
    logic [7:0]  pg_data;
    logic [7:0]  st_m;
    logic [7:0]  st_s;
    logic        dp_m;
    logic        dp_s;
  } link_st_t;
  typedef struct packed {
    logic        write_enable_latch;
    logic [7:0]  status;
    logic [7:0]  stview;
    logic        sleep;
    logic        cs1;
    logic        cs2;
    logic        cs3;
    logic        tg1;
    logic        tg2;
    logic        tg3;
    logic        last_ft;
    logic        prog_we;
    logic [23:0] prog_addr;
    logic [7:0]  prog_data;
    logic        er_req;
    erase_t      er_kind;
    logic [23:0] er_addr;
  } sys_st_t;
endpackage
`default_nettype wire

/* rtl/flash_cmd_decoder.sv */
// serial flash command decoder: link-side frame decoder and system-side executor
//
// Overview of operation
// R1 - opcode 06 alone sets the write enable latch
// R2 - opcode 04 alone clears the write enable latch
// R3 - opcode 9f returns one maker byte then two device bytes
// R4 - opcode 05 returns the status byte with no address or dummy
// R5 - opcode 01 then exactly eight data clocks loads the status register
// R6 - opcode 0d: address in 12 ddr clocks, 6 dummy, ddr bytes on one line
// R7 - opcode bd: address in 6 clocks on two lines, 6 dummy, ddr on two lines
// R8 - opcode ed: address in 3 clocks on four lines, 8 dummy, ddr on four lines
// R9 - opcode 03: 24 address clocks, bytes out on one line until deselect
// R10 - opcode 0b: 24 address clocks, 8 dummy, bytes out on one line
// R11 - opcode bb: 12 address clocks on two lines, 4 dummy, two-line output
// R12 - opcode 3b: 24 address clocks, 8 dummy, output on two lines
// R13 - opcode eb: 6 address clocks on four lines, 6 dummy, four-line output
// R14 - opcode 6b: 24 address clocks, 8 dummy, output on four lines
// R15 - opcode 02 programs on one line, opcode 38 on four lines
// R16 - erase opcodes 20, d8, 52 take an address; 60 and c7 erase all
// R17 - opcode ad takes address and two bytes; later frames continue the address
// R18 - opcode b9 enters deep sleep, opcode ab leaves it
// R19 - opcode ab with 24 dummy clocks returns one signature byte
// R20 - write-type commands only execute when deselect lands on a byte boundary; here each whole program byte is written before deselect
// R21 - single rate samples on rise and drives on fall; ddr uses both edges
// R22 - unknown opcode keeps outputs released until the next frame
// R23 - modifying commands need the latch set; all but opcode ad clear it when done, 02 and 38 only if the frame ends on a multiple of eight clocks
// R24 - first eight bits are the opcode, msb first; deselect restarts decode
// R25 - reads step the address after every byte until deselect
`default_nettype none
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MFR_ID  = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_ID0 = 8'h11,  // arbitrary value
  parameter logic [7:0] DEV_ID1 = 8'h22,  // arbitrary value
  parameter logic [7:0] SIG_ID  = 8'h33   // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  output logic      [23:0] rd_addr_o,
  input  wire logic [7:0]  rd_data_i,
  output logic             prog_we_o,
  output logic      [23:0] prog_addr_o,
  output logic      [7:0]  prog_data_o,
  output logic             erase_req_o,
  output logic      [1:0]  erase_kind_o,
  output logic      [23:0] erase_addr_o,
  output logic             wel_o,
  output logic             sleep_o,
  output logic      [7:0]  status_o
);
  `include "flash_cmd_map.svh"

  link_st_t   ln_q, ln_d, cur;
  sys_st_t    sy_q, sy_d;
  logic       frame_new_q;
  logic       fr_rst;
  logic [3:0] neg_in_q;
  logic [3:0] out_neg_q;
  logic [7:0] take;
  logic [3:0] n;
  logic [7:0] byte_v;
  logic [7:0] chunk;
  logic [7:0] adv;
  cmd_t       c;

  function automatic cmd_t mk(input kind_t k, input logic d, input logic [2:0] aw,
                              input logic [4:0] ac, input logic [4:0] du,
                              input logic [2:0] dw, input logic o);
    cmd_t r;
    r.kind = k;
    r.ddr  = d;
    r.aw   = aw;
    r.aclk = ac;
    r.dum  = du;
    r.dw   = dw;
    r.dout = o;
    return r;
  endfunction

  function automatic cmd_t decode(input logic [7:0] op);
    cmd_t r;
    r = mk(K_NONE, 1'b0, 3'd0, 5'd0, 5'd0, 3'd0, 1'b0);
    case (op)
      `OP_WL_SET:  r.kind = K_WL_SET;  // see R1
      `OP_WL_CLR:  r.kind = K_WL_CLR;  // see R2
      `OP_ID:      r = mk(K_ID, 1'b0, 3'd0, 5'd0, 5'd0, `LANE_1, 1'b1);  // see R3
      `OP_STATUS:  r = mk(K_STATUS, 1'b0, 3'd0, 5'd0, 5'd0, `LANE_1, 1'b1);  // see R4
      `OP_STWR:    r = mk(K_STWR, 1'b0, 3'd0, 5'd0, 5'd0, `LANE_1, 1'b0);  // see R5
      `OP_RD_DDR1: r = mk(K_READ, 1'b1, `LANE_1, `ACLK_12, `DUM_DDR12, `LANE_1, 1'b1);  // see R6
      `OP_RD_DDR2: r = mk(K_READ, 1'b1, `LANE_2, `ACLK_6, `DUM_DDR12, `LANE_2, 1'b1);  // see R7
      `OP_RD_DDR4: r = mk(K_READ, 1'b1, `LANE_4, `ACLK_3, `DUM_DDR4, `LANE_4, 1'b1);  // see R8
      `OP_RD:      r = mk(K_READ, 1'b0, `LANE_1, `ACLK_24, 5'd0, `LANE_1, 1'b1);  // see R9
      `OP_RD_FAST: r = mk(K_READ, 1'b0, `LANE_1, `ACLK_24, `DUM_FAST, `LANE_1, 1'b1);  // see R10
      `OP_RD_2IO:  r = mk(K_READ, 1'b0, `LANE_2, `ACLK_12, `DUM_2IO, `LANE_2, 1'b1);  // see R11
      `OP_RD_2OUT: r = mk(K_READ, 1'b0, `LANE_1, `ACLK_24, `DUM_FAST, `LANE_2, 1'b1);  // see R12
      `OP_RD_4IO:  r = mk(K_READ, 1'b0, `LANE_4, `ACLK_6, `DUM_4IO, `LANE_4, 1'b1);  // see R13
      `OP_RD_4OUT: r = mk(K_READ, 1'b0, `LANE_1, `ACLK_24, `DUM_FAST, `LANE_4, 1'b1);  // see R14
      `OP_PG:      r = mk(K_PROG, 1'b0, `LANE_1, `ACLK_24, 5'd0, `LANE_1, 1'b0);  // see R15
      `OP_PG4:     r = mk(K_PROG, 1'b0, `LANE_4, `ACLK_6, 5'd0, `LANE_4, 1'b0);  // see R15
      `OP_ER_S:    r = mk(K_ER_S, 1'b0, `LANE_1, `ACLK_24, 5'd0, 3'd0, 1'b0);  // see R16
      `OP_ER_H:    r = mk(K_ER_H, 1'b0, `LANE_1, `ACLK_24, 5'd0, 3'd0, 1'b0);  // see R16
      `OP_ER_B:    r = mk(K_ER_B, 1'b0, `LANE_1, `ACLK_24, 5'd0, 3'd0, 1'b0);  // see R16
      `OP_ER_C1,
      `OP_ER_C2:   r.kind = K_ER_C;  // see R16
      `OP_CP:      r = mk(K_CPROG, 1'b0, `LANE_1, `ACLK_24, 5'd0, `LANE_1, 1'b0);  // see R17
      `OP_SLEEP:   r.kind = K_SLEEP;  // see R18
      `OP_WAKE:    r = mk(K_WAKE, 1'b0, 3'd0, 5'd0, `DUM_ES, `LANE_1, 1'b1);  // see R19
      default:     r.kind = K_NONE;  // see R22
    endcase
    return r;
  endfunction

  // picks the phase that follows stage "from" (0 opcode, 1 address, 2 dummy)
  function automatic logic [7:0] advance(input cmd_t k, input logic skip_a,
                                         input logic [1:0] from);
    phase_t     p;
    logic [4:0] m;
    p = PH_IDLE;
    m = 5'd0;
    if (from == 2'd0 && k.aclk != 5'd0 && !skip_a) begin
      p = PH_ADDR;
      m = k.aclk;
    end else if (from != 2'd2 && k.dum != 5'd0) begin
      p = PH_DUM;
      m = k.dum;
    end else if (k.dw != 3'd0) begin
      p = k.dout ? PH_DOUT : PH_DIN;
    end
    return {p, m};
  endfunction

  // ddr pairs the falling-edge sample (earlier) with the rising one
  function automatic logic [7:0] grab(input logic [2:0] w, input logic d,
                                      input logic [3:0] ng, input logic [3:0] ps);
    logic [7:0] r;
    r = 8'h00;
    case (w)
      `LANE_1: r = d ? {6'h00, ng[0], ps[0]} : {7'h00, ps[0]};
      `LANE_2: r = d ? {4'h0, ng[1:0], ps[1:0]} : {6'h00, ps[1:0]};
      `LANE_4: r = d ? {ng, ps} : {4'h0, ps};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // single-line output leaves on io[1], wider output on the low lanes
  function automatic logic [3:0] lanes(input logic [2:0] w, input logic [3:0] x);
    logic [3:0] r;
    case (w)
      `LANE_1: r = {2'b00, x[0], 1'b0};
      `LANE_2: r = {2'b00, x[1:0]};
      `LANE_4: r = x;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] top(input logic [3:0] k, input logic [7:0] b);
    logic [7:0] r;
    case (k)
      4'd1:    r = {7'h00, b[7]};
      4'd2:    r = {6'h00, b[7:6]};
      4'd4:    r = {4'h0, b[7:4]};
      default: r = b;
    endcase
    return r;
  endfunction

  // deselect presets this flag; the first edge of a frame sees it set
  assign fr_rst = sys_rst_i | cs_n_i;
  always_ff @(posedge sclk_i or posedge fr_rst) begin
    if (fr_rst) begin
      frame_new_q <= 1'b1;  // see R24
    end else begin
      frame_new_q <= 1'b0;
    end
  end

  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_in_q  <= 4'h0;
      out_neg_q <= 4'h0;
    end else begin
      neg_in_q  <= io_i;  // see R21
      out_neg_q <= ln_q.out_fall;  // see R21
    end
  end

  always_comb begin
    cur    = ln_q;
    c      = ln_q.cmd;
    take   = 8'h00;
    n      = 4'd0;
    byte_v = ln_q.sh;
    chunk  = 8'h00;
    adv    = 8'h00;
    rd_addr_o = ln_q.addr;
    if (frame_new_q) begin
      cur.phase = PH_OPC;  // see R24
      cur.cnt   = `OPC_CLKS;
      cur.clks  = 12'd0;
      cur.opc   = 8'h00;
      cur.left  = 4'd0;
      cur.idx   = 2'd0;
      cur.oe    = 4'h0;
      cur.ftgl  = ~ln_q.ftgl;
    end
    ln_d      = cur;
    ln_d.st_m = sy_q.stview;
    ln_d.st_s = ln_q.st_m;
    ln_d.dp_m = sy_q.sleep;
    ln_d.dp_s = ln_q.dp_m;
    ln_d.out_rise = 4'h0;
    if (cur.clks != `CLKS_MAX) begin
      ln_d.clks = cur.clks + 12'd1;
    end
    ln_d.cnt = cur.cnt - 5'd1;
    case (cur.phase)
      PH_OPC: begin
        ln_d.opc = {cur.opc[6:0], io_i[0]};  // see R24
        if (cur.cnt == 5'd1) begin
          c = decode(ln_d.opc);
          if (ln_q.dp_s && c.kind != K_WAKE) begin
            c = decode(8'h00);  // see R18
          end
          if (c.kind == K_WL_CLR) begin
            ln_d.cp_on = 1'b0;
          end
          ln_d.cmd = c;
          adv = advance(c, c.kind == K_CPROG && cur.cp_on, 2'd0);  // see R17
          ln_d.phase = phase_t'(adv[7:5]);
          ln_d.cnt   = adv[4:0];
        end
      end
      PH_ADDR: begin
        take = grab(cur.cmd.aw, cur.cmd.ddr, neg_in_q, io_i);
        n = cur.cmd.ddr ? {cur.cmd.aw, 1'b0} : {1'b0, cur.cmd.aw};
        ln_d.addr = 24'(cur.addr << n) | {16'h0000, take};
        if (cur.cnt == 5'd1) begin
          ln_d.cp_on = cur.cmd.kind == K_CPROG;
          adv = advance(cur.cmd, 1'b0, 2'd1);
          ln_d.phase = phase_t'(adv[7:5]);
          ln_d.cnt   = adv[4:0];
        end
      end
      PH_DUM: begin
        if (cur.cnt == 5'd1) begin
          adv = advance(cur.cmd, 1'b0, 2'd2);
          ln_d.phase = phase_t'(adv[7:5]);
          ln_d.cnt   = adv[4:0];
        end
      end
      PH_DIN: begin
        take = grab(cur.cmd.dw, 1'b0, neg_in_q, io_i);
        n = {1'b0, cur.cmd.dw};
        ln_d.sh   = 8'(cur.sh << n) | take;
        ln_d.left = cur.left + n;
        if (ln_d.left == `BYTE_BITS) begin
          ln_d.left = 4'd0;
          if (cur.cmd.kind == K_STWR) begin
            ln_d.phase = PH_IDLE;  // see R5
          end else begin
            // whole bytes only, so a trailing partial byte is never written
            ln_d.pg_tgl  = ~cur.pg_tgl;  // see R20
            ln_d.pg_addr = cur.addr;
            ln_d.pg_data = ln_d.sh;
            if (cur.cmd.kind == K_CPROG) begin
              ln_d.addr = cur.addr + 24'd1;  // see R17
              ln_d.idx  = cur.idx + 2'd1;
              if (cur.idx == 2'd1) begin
                ln_d.phase = PH_IDLE;
              end
            end else begin
              // page wraps on its low byte like a real page buffer
              ln_d.addr = {cur.addr[23:8], cur.addr[7:0] + 8'd1};  // see R15
            end
          end
        end
      end
      PH_DOUT: begin
      end
      PH_IDLE: begin
        ln_d.phase = PH_IDLE;  // see R22
      end
      default: begin
        ln_d.phase = PH_IDLE;
      end
    endcase
    ln_d.oe = 4'h0;  // see R22
    if (ln_d.phase == PH_DOUT) begin
      n = ln_d.cmd.ddr ? {ln_d.cmd.dw, 1'b0} : {1'b0, ln_d.cmd.dw};
      if (ln_d.left == 4'd0) begin
        case (ln_d.cmd.kind)
          K_ID: begin
            byte_v = (ln_d.idx == 2'd0) ? MFR_ID :
                     (ln_d.idx == 2'd1) ? DEV_ID0 : DEV_ID1;  // see R3
            ln_d.idx = (ln_d.idx == 2'd2) ? 2'd0 : ln_d.idx + 2'd1;
          end
          K_STATUS: byte_v = ln_q.st_s;  // see R4
          K_WAKE:   byte_v = SIG_ID;  // see R19
          default: begin
            rd_addr_o = ln_d.addr;
            byte_v    = rd_data_i;
            ln_d.addr = ln_d.addr + 24'd1;  // see R25
          end
        endcase
        ln_d.left = `BYTE_BITS;
      end
      chunk = top(n, byte_v);
      ln_d.sh   = 8'(byte_v << n);
      ln_d.left = ln_d.left - n;
      ln_d.oe   = lanes(ln_d.cmd.dw, 4'hf);
      if (ln_d.cmd.ddr) begin
        ln_d.out_fall = lanes(ln_d.cmd.dw, 4'(chunk >> ln_d.cmd.dw));  // see R21
        ln_d.pend     = lanes(ln_d.cmd.dw, chunk[3:0]);
        ln_d.out_rise = (cur.phase == PH_DOUT) ? cur.pend : 4'h0;  // see R21
      end else begin
        ln_d.out_fall = lanes(ln_d.cmd.dw, chunk[3:0]);
      end
    end
  end

  always_ff @(posedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  // rise half of a ddr pair is driven while the clock is high
  assign io_o    = (ln_q.cmd.ddr && sclk_i) ? ln_q.out_rise : out_neg_q;
  assign io_oe_o = frame_new_q ? 4'h0 : ln_q.oe;  // see R22

  // frame results are read only after deselect has passed two flops, program bytes after their toggle has;
  // the link clock is idle or between bytes then, so the link fields are stable
  always_comb begin
    sy_d         = sy_q;
    sy_d.cs1     = cs_n_i;
    sy_d.cs2     = sy_q.cs1;
    sy_d.cs3     = sy_q.cs2;
    sy_d.tg1     = ln_q.pg_tgl;
    sy_d.tg2     = sy_q.tg1;
    sy_d.tg3     = sy_q.tg2;
    sy_d.prog_we = 1'b0;
    sy_d.er_req  = 1'b0;
    if ((sy_q.tg2 ^ sy_q.tg3) && sy_q.write_enable_latch) begin
      sy_d.prog_we   = 1'b1;  // see R23
      sy_d.prog_addr = ln_q.pg_addr;
      sy_d.prog_data = ln_q.pg_data;
    end
    if (sy_q.cs2 && !sy_q.cs3 && ln_q.ftgl != sy_q.last_ft) begin
      sy_d.last_ft = ln_q.ftgl;
      case (ln_q.cmd.kind)
        K_WL_SET: begin
          if (ln_q.clks == `CLKS_BARE) sy_d.write_enable_latch = 1'b1;  // see R1
        end
        K_WL_CLR: begin
          if (ln_q.clks == `CLKS_BARE) sy_d.write_enable_latch = 1'b0;  // see R2
        end
        K_STWR: begin
          if (sy_q.write_enable_latch && ln_q.clks == `CLKS_STWR) begin  // see R20
            sy_d.status = (ln_q.sh & `STAT_WR_MSK) |
                          (sy_q.status & ~`STAT_WR_MSK);  // see R5
            sy_d.write_enable_latch    = 1'b0;  // see R23
          end
        end
        K_ER_S, K_ER_H, K_ER_B, K_ER_C: begin
          if (sy_q.write_enable_latch && ln_q.clks ==
              ((ln_q.cmd.kind == K_ER_C) ? `CLKS_BARE : `CLKS_ADDR)) begin  // see R20
            sy_d.er_req  = 1'b1;  // see R16
            sy_d.er_kind = erase_t'(ln_q.cmd.kind[1:0]);
            sy_d.er_addr = ln_q.addr;
            sy_d.write_enable_latch     = 1'b0;  // see R23
          end
        end
        K_PROG: begin
          if (ln_q.clks[2:0] == 3'd0) sy_d.write_enable_latch = 1'b0;  // see R23
        end
        K_SLEEP: begin
          if (ln_q.clks == `CLKS_BARE) sy_d.sleep = 1'b1;  // see R18
        end
        K_WAKE: sy_d.sleep = 1'b0;  // see R18
        default: begin
        end
      endcase
    end
    sy_d.stview = (sy_d.status & `STAT_WR_MSK) | 8'({sy_d.write_enable_latch} << `STAT_WEL);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sy_q        <= '0;
      sy_q.status <= `STAT_RST;
      sy_q.stview <= `STAT_RST;
      sy_q.cs1    <= 1'b1;
      sy_q.cs2    <= 1'b1;
      sy_q.cs3    <= 1'b1;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign prog_we_o    = sy_q.prog_we;
  assign prog_addr_o  = sy_q.prog_addr;
  assign prog_data_o  = sy_q.prog_data;
  assign erase_req_o  = sy_q.er_req;
  assign erase_kind_o = sy_q.er_kind;
  assign erase_addr_o = sy_q.er_addr;
  assign wel_o        = sy_q.write_enable_latch;
  assign sleep_o      = sy_q.sleep;
  assign status_o     = sy_q.stview;
endmodule
`default_nettype wire

/* test/flash_cmd_decoder_chk.sv */
// concurrent checks on the ports of the flash command decoder
`default_nettype none
module flash_cmd_decoder_chk (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic       prog_we_o,
  input wire logic       erase_req_o,
  input wire logic [1:0] erase_kind_o,
  input wire logic       wel_o,
  input wire logic       sleep_o,
  input wire logic [7:0] status_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // cs_n is asynchronous here, so two samples give the synchronizer time to see it
  sequence s_desel;
    cs_n_i ##1 cs_n_i;
  endsequence
  sequence s_quiet_erase;
    !erase_req_o [*3];
  endsequence
  property p_oe_idle;
    s_desel |-> io_oe_o == 4'h0;
  endproperty
  property p_erase_once;
    erase_req_o |=> s_quiet_erase;
  endproperty
  property p_erase_gated;
    erase_req_o |-> $past(wel_o) && !wel_o;
  endproperty
  property p_erase_desel;
    erase_req_o |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  property p_prog_once;
    prog_we_o |=> !prog_we_o [*4];
  endproperty
  property p_prog_gated;
    prog_we_o |-> wel_o;
  endproperty
  property p_wel_desel;
    $changed(wel_o) |-> cs_n_i && $past(cs_n_i);
  endproperty
  property p_sleep_desel;
    $changed(sleep_o) |-> cs_n_i && $past(cs_n_i);
  endproperty
  property p_wel_status;
    $changed(wel_o) |-> ##[0:1] status_o[1] == wel_o;
  endproperty
  property p_kind_hold;
    $changed(erase_kind_o) |-> erase_req_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while deselected");
  a_erase_once: assert property (p_erase_once) else $error("erase request too long");
  a_erase_gated: assert property (p_erase_gated) else $error("erase latch misuse");
  a_erase_desel: assert property (p_erase_desel) else $error("erase before deselect");
  a_prog_once: assert property (p_prog_once) else $error("program strobe too long");
  a_prog_gated: assert property (p_prog_gated) else $error("program without latch");
  a_wel_desel: assert property (p_wel_desel) else $error("latch moved in frame");
  a_sleep_desel: assert property (p_sleep_desel) else $error("sleep moved in frame");
  a_wel_status: assert property (p_wel_status) else $error("status latch bit stale");
  a_kind_hold: assert property (p_kind_hold) else $error("erase kind moved alone");
endmodule
bind flash_cmd_decoder flash_cmd_decoder_chk chk_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
  .prog_we_o(prog_we_o), .erase_req_o(erase_req_o), .erase_kind_o(erase_kind_o),
  .wel_o(wel_o), .sleep_o(sleep_o), .status_o(status_o));
`default_nettype wire

/* test/flash_host_model.sv */
// host serial controller model: frames commands and collects one, two or four-line replies
`default_nettype none
module flash_host_model (
  output var logic       sclk_o,
  output var logic       cs_n_o,
  output var logic [3:0] io_o,
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx = '0;
  logic        oe_seen = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // sclk only runs inside a frame, as a real controller parks it
  task automatic frame(input logic [63:0] bits, input int n_out, input int n_in,
                       input int wi = 1, input int wo = 1);
    int k;
    rx = '0;
    oe_seen = 1'b0;
    #3 cs_n_o = 1'b0;
    #20;
    // opcode always on io[0]; later clocks carry wi bits, msb on the top lane
    for (int i = n_out - 1; i >= 0; i -= k) begin
      k = (i >= n_out - 8) ? 1 : wi;
      io_o = 4'(bits >> (i - k + 1)) & 4'((1 << k) - 1);
      #32 sclk_o = 1'b1;
      oe_seen = oe_seen | (|dev_oe_i);
      #32 sclk_o = 1'b0;
    end
    for (int i = 0; i < n_in; i++) begin
      io_o = ~io_o; // released lanes must not hold the last value
      #32 rx = (wo == 4) ? {rx[27:0], dev_io_i} :
               (wo == 2) ? {rx[29:0], dev_io_i[1:0]} : {rx[30:0], dev_io_i[1]};
      oe_seen = oe_seen | (|dev_oe_i);
      sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

/* test/flash_cmd_decoder_tb.sv */
// self-checking bench for the flash command decoder
`default_nettype none
`include "flash_cmd_map.svh"
module flash_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %0t: mismatch got %h expected %h", $time, (got), (exp)); end end
  localparam logic [7:0] MFR = 8'h4e;  // arbitrary value
  localparam logic [7:0] DV0 = 8'h71;  // arbitrary value
  localparam logic [7:0] DV1 = 8'h96;  // arbitrary value
  localparam logic [7:0] SIG = 8'h3d;  // arbitrary value
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sclk, cs_n, prog_we, erase_req, write_enable_latch, sleep;
  logic [3:0]  io_h, io_d, io_oe;
  logic [23:0] rd_addr, prog_addr, erase_addr;
  logic [7:0]  rd_data, prog_data, status;
  logic [1:0]  erase_kind;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n_prog = 0;
  int          n_erase = 0;
  always #2 clk_i = ~clk_i;
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  assign rd_data = mem(rd_addr);
  always @(posedge clk_i) begin
    if (prog_we) n_prog++;
    if (erase_req) n_erase++;
  end
  flash_host_model flash_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_h),
    .dev_io_i(io_d), .dev_oe_i(io_oe));
  flash_cmd_decoder #(.MFR_ID(MFR), .DEV_ID0(DV0), .DEV_ID1(DV1), .SIG_ID(SIG))
  flash_cmd_decoder_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_h),
    .io_o(io_d), .io_oe_o(io_oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .prog_we_o(prog_we), .prog_addr_o(prog_addr), .prog_data_o(prog_data),
    .erase_req_o(erase_req), .erase_kind_o(erase_kind), .erase_addr_o(erase_addr),
    .wel_o(write_enable_latch), .sleep_o(sleep), .status_o(status));
  task automatic cmd(input logic [63:0] b, input int n_out, input int n_in,
                     input int wi = 1, input int wo = 1);
    @(negedge clk_i);
    flash_host_model_inst.frame(b, n_out, n_in, wi, wo);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    $display("ERROR %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    logic [23:0] a;
    logic [7:0]  d;
    int          e0;
    static logic [7:0] ops [5] = '{`OP_ER_S, `OP_ER_H, `OP_ER_B, `OP_ER_C1, `OP_ER_C2};
    static logic [1:0] kinds [5] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd3};
    void'($urandom(32'h9538));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHECK(status, `STAT_RST)
    `CHECK(write_enable_latch, 1'b0)
    $display("test reset done");
    cmd({`OP_WL_SET, 1'b0}, 9, 0);
    `CHECK(write_enable_latch, 1'b0)
    cmd(`OP_WL_SET, 8, 0);
    `CHECK(write_enable_latch, 1'b1)
    cmd(`OP_STATUS, 8, 8);
    `CHECK(flash_host_model_inst.rx[7:0], 8'h02)
    cmd(`OP_WL_CLR, 8, 0);
    `CHECK(write_enable_latch, 1'b0)
    d = 8'($urandom);
    cmd(`OP_WL_SET, 8, 0);
    cmd({`OP_STWR, d}, 16, 0);
    `CHECK(status, d & `STAT_WR_MSK)
    `CHECK(write_enable_latch, 1'b0)
    cmd({`OP_STWR, ~d}, 16, 0);
    `CHECK(status, d & `STAT_WR_MSK)
    cmd(`OP_ID, 8, 24);
    `CHECK(flash_host_model_inst.rx[23:0], {MFR, DV0, DV1})
    $display("test latch status id done");
    for (int k = 0; k < 8; k++) begin
      a = (k == 0) ? 24'hffffff : 24'($urandom);
      case (k)
        1, 3: cmd({`OP_RD_FAST, a, 8'h00}, 40, 16);
        4: cmd({`OP_RD_2IO, a, 8'h00}, 40, 8, 2, 2);
        5: cmd({`OP_RD_2OUT, a, 8'h00}, 40, 8, 1, 2);
        6: cmd({`OP_RD_4IO, a, 24'h0}, 56, 4, 4, 4);
        7: cmd({`OP_RD_4OUT, a, 8'h00}, 40, 4, 1, 4);
        default: cmd({`OP_RD, a}, 32, 16);
      endcase
      `CHECK(flash_host_model_inst.rx[15:0], {mem(a), mem(a + 24'd1)})
      `CHECK(flash_host_model_inst.oe_seen, 1'b1)
    end
    $display("test reads done");
    for (int k = 0; k < 5; k++) begin
      a = 24'($urandom);
      cmd(`OP_WL_SET, 8, 0);
      e0 = n_erase;
      if (k < 3) cmd({ops[k], a}, 32, 0);
      else cmd(ops[k], 8, 0);
      `CHECK(n_erase, e0 + 1)
      `CHECK(erase_kind, kinds[k])
      if (k < 3) `CHECK(erase_addr, a)
      `CHECK(write_enable_latch, 1'b0)
    end
    cmd({`OP_ER_S, a}, 32, 0);
    `CHECK(n_erase, e0 + 1)
    $display("test erase done");
    a = 24'($urandom) | 24'hff;
    d = 8'($urandom);
    cmd(`OP_WL_SET, 8, 0);
    e0 = n_prog;
    cmd({`OP_PG, a, d, ~d}, 48, 0);
    `CHECK(n_prog, e0 + 2)
    `CHECK(prog_data, ~d)
    `CHECK(prog_addr, {a[23:8], 8'h00})
    `CHECK(write_enable_latch, 1'b0)
    cmd({`OP_PG, a, d}, 40, 0);
    `CHECK(n_prog, e0 + 2)
    cmd(`OP_WL_SET, 8, 0);
    cmd({`OP_PG4, a, d}, 40, 0, 4);
    `CHECK(n_prog, e0 + 3)
    `CHECK(prog_addr, a)
    cmd(`OP_WL_SET, 8, 0);
    cmd({`OP_CP, a, d, ~d}, 48, 0);
    cmd({`OP_CP, ~d, d}, 24, 0);
    `CHECK(n_prog, e0 + 7)
    `CHECK(prog_addr, a + 24'd3)
    `CHECK(prog_data, d)
    cmd(`OP_WL_CLR, 8, 0);
    `CHECK(write_enable_latch, 1'b0)
    $display("test program done");
    cmd(`OP_SLEEP, 8, 0);
    `CHECK(sleep, 1'b1)
    cmd(`OP_ID, 8, 24);
    `CHECK(flash_host_model_inst.oe_seen, 1'b0)
    cmd({`OP_WAKE, 24'h0}, 32, 8);
    `CHECK(flash_host_model_inst.rx[7:0], SIG)
    `CHECK(sleep, 1'b0)
    cmd(8'hff, 8, 16);
    `CHECK(flash_host_model_inst.oe_seen, 1'b0)
    $display("test sleep and refusal done");
    wrap_up();
  end
endmodule
`default_nettype wire
